//--- inc/mss_cfg.svh
// Purpose: Constants for the motor starter supervisor.
// Assumes: Included by its bare name.
// Notes: Times are counted in scan clock ticks.
`ifndef MSS_CFG_SVH
`define MSS_CFG_SVH
`define MSS_CLK_NS 50
`define MSS_TIME_W 16
`define MSS_MON_TICKS_DEF 16'h0064
`define MSS_RDY_TICKS_DEF 16'h00C8
`define MSS_ADDR_W 4
`define MSS_OFS_CTRL 4'h0
`define MSS_OFS_MON 4'h1
`define MSS_OFS_RDY 4'h2
`define MSS_OFS_STAT 4'h3
`define MSS_OFS_IRQ_STAT 4'h4
`define MSS_OFS_IRQ_CLR 4'h5
`define MSS_OFS_IRQ_EN 4'h6
`define MSS_OFS_ALARM_EN 4'h7
`define MSS_CTRL_JOG_INHIBIT 0
`define MSS_CTRL_AUTO 1
`define MSS_CTRL_LOCAL 2
`define MSS_CTRL_CHECK 3
`define MSS_CTRL_RST 4'h1
`define MSS_EV_W 4
`define MSS_EV_FAIL 0
`define MSS_EV_RUN 1
`define MSS_EV_STOP 2
`define MSS_EV_ALARM 3
`endif

//--- inc/mss_pkg.sv
// Purpose: Types for the motor starter supervisor.
// Assumes: Configuration header is on the include path.
// Notes: Field inputs travel together as one struct.
`include "mss_cfg.svh"
package mss_pkg;
    typedef enum logic [2:0] {
        MSS_IDLE = 3'h0,
        MSS_STARTING = 3'h1,
        MSS_RUNNING = 3'h3,
        MSS_FAILED = 3'h2
    } mss_state_t;
    typedef struct packed {
        logic feedback;
        logic safety_ok;
        logic machine_protect_ok;
        logic isolator_ok;
        logic supply_ok;
        logic thermal_ok;
        logic local_start;
    } mss_field_t;
    typedef struct packed {
        logic start;
        logic stop;
        logic restart;
        logic ack;
        logic jog;
    } mss_cmd_t;
endpackage : mss_pkg

//--- src/mss_supervisor.sv
// Purpose: Supervises one motor or valve starter with feedback and interlock checks.
// Assumes: All inputs are synchronous to clock; registers on a simple strobe port.
// Notes: Status alarm inputs are gated by the check flag in the control register.
`timescale 1ns/10ps
`include "mss_cfg.svh"
module mss_supervisor (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    // Field side.
    input wire mss_pkg::mss_field_t field,
    input wire logic [7:0] status_alarm_in,
    output logic start_cmd,
    // Parent control group and operator.
    input wire mss_pkg::mss_cmd_t cmd,
    output logic running,
    output logic ready_for_auto,
    output logic alarm,
    output logic failed,
    output logic irq,
    // Register port.
    input wire logic [`MSS_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata
);
    import mss_pkg::*;

    typedef struct packed {
        mss_state_t st;
        logic [`MSS_TIME_W-1:0] tmr;
        logic [`MSS_TIME_W-1:0] mon_time;
        logic [`MSS_TIME_W-1:0] rdy_time;
        logic [3:0] ctrl;
        logic [7:0] alarm_en;
        logic [`MSS_EV_W-1:0] ev_stat;
        logic [`MSS_EV_W-1:0] ev_en;
        logic fail_latch;
        logic alarm_latch;
        logic jogging;
        logic start_cmd;
        logic running;
        logic ready;
        logic irq;
        logic [15:0] rdata;
    } mss_regs_t;

    mss_regs_t s_reg;
    mss_regs_t s_next;

    logic jog_inhibit;
    logic auto_mode;
    logic local_mode;
    logic check_flag;
    logic perm_ok;
    logic alarm_cond;
    logic stopping;
    logic fb_ok;
    logic [`MSS_EV_W-1:0] ev;

    // Permissives; safety interlock can never be bridged, protection only by local start.
    function automatic logic run_permit(input mss_field_t f, input logic loc);
        run_permit = f.safety_ok & (f.machine_protect_ok | (loc & f.local_start))
            & f.isolator_ok & f.supply_ok & f.thermal_ok;
    endfunction : run_permit

    // Control bits decoded from the control register.
    always_comb begin
        jog_inhibit = s_reg.ctrl[`MSS_CTRL_JOG_INHIBIT];
        auto_mode = s_reg.ctrl[`MSS_CTRL_AUTO];
        local_mode = s_reg.ctrl[`MSS_CTRL_LOCAL];
        check_flag = s_reg.ctrl[`MSS_CTRL_CHECK];
        perm_ok = run_permit(field, local_mode);
        fb_ok = field.feedback;
        alarm_cond = check_flag & (|(status_alarm_in & s_reg.alarm_en));
    end

    // Next-state logic: sequence, timers, alarm latch and registers in one place.
    always_comb begin
        s_next = s_reg;
        ev = '0;
        stopping = 1'b0;
        case (s_reg.st)
            MSS_IDLE: begin
                s_next.tmr = '0;
                if (cmd.start && perm_ok) begin
                    s_next.st = MSS_STARTING;
                    s_next.start_cmd = 1'b1;
                    s_next.jogging = 1'b0;
                end else if (cmd.jog && !jog_inhibit && perm_ok) begin
                    s_next.st = MSS_STARTING;
                    s_next.start_cmd = 1'b1;
                    s_next.jogging = 1'b1;
                end
            end
            MSS_STARTING: begin
                // Equality keeps the compare small; shrinking a time mid-count lets the timer run round.
                if (s_reg.tmr != s_reg.mon_time) begin
                    s_next.tmr = s_reg.tmr + 1'b1;
                end
                if (!perm_ok) begin
                    s_next.st = MSS_FAILED;
                end else if (s_reg.tmr == s_reg.mon_time) begin
                    if (fb_ok) begin
                        s_next.st = MSS_RUNNING;
                        s_next.running = 1'b1;
                        s_next.tmr = '0;
                        ev[`MSS_EV_RUN] = 1'b1;
                    end else begin
                        s_next.st = MSS_FAILED;
                    end
                end
            end
            MSS_RUNNING: begin
                if (s_reg.tmr != s_reg.rdy_time) begin
                    s_next.tmr = s_reg.tmr + 1'b1;
                end else if (auto_mode) begin
                    s_next.ready = 1'b1;
                end
                if (!perm_ok || !fb_ok) begin
                    s_next.st = MSS_FAILED;
                end
            end
            MSS_FAILED: begin
                if (cmd.restart) begin
                    s_next.st = MSS_IDLE;
                end
            end
            default: begin
                s_next.st = MSS_IDLE;
            end
        endcase
        // Operator stop, jog release or failure ends the run at once.
        if (s_reg.st != MSS_IDLE && s_reg.st != MSS_FAILED &&
            (cmd.stop || (s_reg.jogging && !cmd.jog))) begin
            s_next.st = MSS_IDLE;
        end
        if (s_next.st == MSS_IDLE || s_next.st == MSS_FAILED) begin
            stopping = s_reg.start_cmd;
            s_next.start_cmd = 1'b0;
            s_next.running = 1'b0;
            s_next.ready = 1'b0;
            s_next.jogging = 1'b0;
        end
        if (s_next.st == MSS_FAILED && s_reg.st != MSS_FAILED) begin
            s_next.fail_latch = 1'b1;
            ev[`MSS_EV_FAIL] = 1'b1;
        end
        if (s_reg.st == MSS_FAILED && s_next.st == MSS_IDLE) begin
            s_next.fail_latch = 1'b0;
        end
        ev[`MSS_EV_STOP] = stopping;
        // Alarm holds until conditions are gone and then an acknowledge arrives.
        if (alarm_cond || s_next.fail_latch) begin
            s_next.alarm_latch = 1'b1;
            ev[`MSS_EV_ALARM] = ~s_reg.alarm_latch;
        end else if (cmd.ack) begin
            s_next.alarm_latch = 1'b0;
        end
        // Register writes.
        if (reg_wr) begin
            case (reg_addr)
                `MSS_OFS_CTRL: s_next.ctrl = reg_wdata[3:0];
                `MSS_OFS_MON: s_next.mon_time = reg_wdata;
                `MSS_OFS_RDY: s_next.rdy_time = reg_wdata;
                `MSS_OFS_IRQ_CLR: s_next.ev_stat = s_reg.ev_stat & ~reg_wdata[`MSS_EV_W-1:0];
                `MSS_OFS_IRQ_EN: s_next.ev_en = reg_wdata[`MSS_EV_W-1:0];
                `MSS_OFS_ALARM_EN: s_next.alarm_en = reg_wdata[7:0];
                default: begin
                end
            endcase
        end
        // A new event wins over a clear in the same cycle.
        s_next.ev_stat = s_next.ev_stat | ev;
        s_next.irq = |(s_next.ev_stat & s_next.ev_en);
        // Reads answer one cycle later; unmapped addresses read zero.
        s_next.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                `MSS_OFS_CTRL: s_next.rdata = {12'h000, s_reg.ctrl};
                `MSS_OFS_MON: s_next.rdata = s_reg.mon_time;
                `MSS_OFS_RDY: s_next.rdata = s_reg.rdy_time;
                `MSS_OFS_STAT: s_next.rdata = {9'h000, s_reg.st, s_reg.fail_latch, s_reg.alarm_latch,
                    s_reg.running, s_reg.ready};
                `MSS_OFS_IRQ_STAT: s_next.rdata = {12'h000, s_reg.ev_stat};
                `MSS_OFS_IRQ_EN: s_next.rdata = {12'h000, s_reg.ev_en};
                `MSS_OFS_ALARM_EN: s_next.rdata = {8'h00, s_reg.alarm_en};
                default: s_next.rdata = '0;
            endcase
        end
    end

    // State register; clock enable freezes everything.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.st <= MSS_IDLE;
            s_reg.mon_time <= `MSS_MON_TICKS_DEF;
            s_reg.rdy_time <= `MSS_RDY_TICKS_DEF;
            s_reg.ctrl <= `MSS_CTRL_RST;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign start_cmd = s_reg.start_cmd;
    assign running = s_reg.running;
    assign ready_for_auto = s_reg.ready;
    assign alarm = s_reg.alarm_latch;
    assign failed = s_reg.fail_latch;
    assign irq = s_reg.irq;
    assign reg_rdata = s_reg.rdata;

    // Checks on the sequence.
    sequence seq_starting;
        s_reg.st == MSS_STARTING && s_reg.tmr == s_reg.mon_time;
    endsequence
    // An operator stop or a jog release outranks a fault in the same cycle, so those cycles are left out.
    sequence seq_no_stop;
        clk_en && !cmd.stop && !(s_reg.jogging && !cmd.jog);
    endsequence
    sequence seq_active_loss;
        (s_reg.st == MSS_STARTING || s_reg.st == MSS_RUNNING) && !perm_ok;
    endsequence
    chk_late_feedback_fail: assert property (@(posedge clock) disable iff (!nrst)
        (seq_starting ##0 seq_no_stop ##0 !fb_ok) |=> failed)
        else $error("Late feedback did not fail.");
    chk_fb_loss_fail: assert property (@(posedge clock) disable iff (!nrst)
        (seq_no_stop ##0 (running && !fb_ok)) |=> (failed && !running))
        else $error("Feedback loss did not fail.");
    chk_safety_run: assert property (@(posedge clock) disable iff (!nrst)
        (clk_en && !field.safety_ok) |=> !running)
        else $error("Running without safety interlock.");
    chk_protect_bridge: assert property (@(posedge clock) disable iff (!nrst)
        (clk_en && !field.machine_protect_ok && !(local_mode && field.local_start)) |=> !start_cmd)
        else $error("Protection interlock not honoured.");
    chk_jog_inhibit: assert property (@(posedge clock) disable iff (!nrst)
        (clk_en && s_reg.st == MSS_IDLE && jog_inhibit && !cmd.start) |=> !start_cmd)
        else $error("Jog ran while inhibited.");
    chk_run_cmd: assert property (@(posedge clock) disable iff (!nrst)
        running |-> start_cmd)
        else $error("Running without start command.");
    chk_fail_alarm: assert property (@(posedge clock) disable iff (!nrst)
        failed |-> alarm)
        else $error("Failure without alarm.");
    chk_alarm_hold: assert property (@(posedge clock) disable iff (!nrst)
        (alarm && clk_en && !cmd.ack) |=> alarm)
        else $error("Alarm cleared without acknowledge.");
    chk_check_gate: assert property (@(posedge clock) disable iff (!nrst)
        (!alarm && clk_en && !check_flag && !s_next.fail_latch) |=> !alarm)
        else $error("Alarm raised without check flag.");
    chk_run_rise: assert property (@(posedge clock) disable iff (!nrst)
        $rose(running) |-> ($past(fb_ok) && $past(s_reg.tmr) == $past(s_reg.mon_time)))
        else $error("Running rose early.");
    chk_stop_drop: assert property (@(posedge clock) disable iff (!nrst)
        (running && clk_en && cmd.stop) |=> (!running && !ready_for_auto))
        else $error("Outputs not dropped on stop.");
    chk_ready_rise: assert property (@(posedge clock) disable iff (!nrst)
        $rose(ready_for_auto) |-> (running && auto_mode && s_reg.tmr == s_reg.rdy_time))
        else $error("Ready rose before delay.");

    // Failure handling: a latched failure needs the parent group's restart and nothing else.
    chk_fail_restart: assert property (@(posedge clock) disable iff (!nrst)
        (failed && clk_en && !cmd.restart) |=> failed)
        else $error("Failure left without restart.");
    chk_restart_clear: assert property (@(posedge clock) disable iff (!nrst)
        (failed && clk_en && cmd.restart) |=> !failed)
        else $error("Restart did not clear the failure.");
    chk_interlock_fail: assert property (@(posedge clock) disable iff (!nrst)
        (seq_active_loss ##0 seq_no_stop) |=> failed)
        else $error("Interlock loss in an active state not recorded.");

    // Start permission: every chain is checked before the coil is energised.
    chk_safety_start: assert property (@(posedge clock) disable iff (!nrst)
        (clk_en && !field.safety_ok) |=> !start_cmd)
        else $error("Coil energised without safety interlock.");
    chk_perm_start: assert property (@(posedge clock) disable iff (!nrst)
        (clk_en && s_reg.st == MSS_IDLE && !perm_ok) |=> !start_cmd)
        else $error("Start taken with a permissive missing.");
    chk_start_cmd_on: assert property (@(posedge clock) disable iff (!nrst)
        (clk_en && s_reg.st == MSS_IDLE && cmd.start && perm_ok) |=> start_cmd)
        else $error("Start command not raised.");
    chk_jog_release: assert property (@(posedge clock) disable iff (!nrst)
        (clk_en && s_reg.jogging && !cmd.jog) |=> !start_cmd)
        else $error("Jog kept running after release.");

    // Timing: the monitor and ready times are whole numbers of scan ticks.
    chk_start_timer: assert property (@(posedge clock) disable iff (!nrst)
        (clk_en && s_reg.st == MSS_STARTING && s_reg.tmr != s_reg.mon_time) |=>
        (s_reg.tmr == $past(s_reg.tmr) + 16'h0001))
        else $error("Monitor timer skipped a tick.");
    chk_mon_wait: assert property (@(posedge clock) disable iff (!nrst)
        (s_reg.st == MSS_STARTING && s_reg.tmr != s_reg.mon_time) |=> !running)
        else $error("Running rose before the monitor time.");

    // Run and ready outputs: both go down together with the coil.
    chk_run_drop_fail: assert property (@(posedge clock) disable iff (!nrst)
        (running && clk_en && !perm_ok) |=> !running)
        else $error("Running kept after an interlock loss.");
    chk_stop_coil: assert property (@(posedge clock) disable iff (!nrst)
        (start_cmd && clk_en && cmd.stop) |=> !start_cmd)
        else $error("Coil kept after a stop.");
    chk_ready_drop: assert property (@(posedge clock) disable iff (!nrst)
        (ready_for_auto && clk_en && !perm_ok) |=> !ready_for_auto)
        else $error("Ready kept after an interlock loss.");
    chk_ready_run: assert property (@(posedge clock) disable iff (!nrst)
        ready_for_auto |-> running)
        else $error("Ready without running.");
    chk_ready_manual: assert property (@(posedge clock) disable iff (!nrst)
        (clk_en && !auto_mode && !ready_for_auto) |=> !ready_for_auto)
        else $error("Ready rose outside auto mode.");

    // Alarm latch: any enabled condition sets it, only a clean acknowledge clears it.
    chk_alarm_rise: assert property (@(posedge clock) disable iff (!nrst)
        (clk_en && alarm_cond) |=> alarm)
        else $error("Enabled status alarm not latched.");
    chk_ack_clear: assert property (@(posedge clock) disable iff (!nrst)
        (alarm && clk_en && cmd.ack && !alarm_cond && !s_next.fail_latch) |=> !alarm)
        else $error("Acknowledge did not clear the alarm.");

    // Register port: read data stand for the one cycle after the strobe only.
    chk_rdata_idle: assert property (@(posedge clock) disable iff (!nrst)
        (clk_en && !reg_rd) |=> (reg_rdata == 16'h0000))
        else $error("Read data left standing.");
    chk_rdata_stat: assert property (@(posedge clock) disable iff (!nrst)
        (clk_en && reg_rd && reg_addr == `MSS_OFS_STAT) |=>
        (reg_rdata[1:0] == {$past(running), $past(ready_for_auto)}))
        else $error("Status read does not match the outputs.");
endmodule : mss_supervisor

//--- bench/mss_field_model.sv
// Purpose: Contactor and interlock chains on the field side of the supervisor.
// Assumes: One scan clock; the bench sets the chain levels and the pull-in delay.
// Notes: Feedback drops the moment the coil is released, as a real contactor would.
`timescale 1ns/10ps
module mss_field_model (
    // Scan clock.
    input wire logic clock,
    input wire logic nrst,
    // Coil command from the supervisor.
    input wire logic start_cmd,
    // Bench controls.
    input wire logic [3:0] fb_delay,
    input wire logic fb_cut,
    input wire logic [4:0] perm,
    input wire logic local_start,
    // Field inputs of the supervisor.
    output mss_pkg::mss_field_t field
);
    import mss_pkg::*;
    logic [3:0] pull_reg;

    // Counts coil-on ticks; a long delay makes the contactor late on purpose.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pull_reg <= 4'h0;
        end else if (!start_cmd) begin
            pull_reg <= 4'h0;
        end else if (pull_reg != 4'hF) begin
            pull_reg <= pull_reg + 4'h1;
        end
    end

    // Chains in order safety, protection, isolator, supply, thermal.
    always_comb begin
        field.feedback = start_cmd && (pull_reg >= fb_delay) && !fb_cut;
        field.safety_ok = perm[4];
        field.machine_protect_ok = perm[3];
        field.isolator_ok = perm[2];
        field.supply_ok = perm[1];
        field.thermal_ok = perm[0];
        field.local_start = local_start;
    end
endmodule : mss_field_model

//--- bench/mss_supervisor_tb_top.sv
// Purpose: Self-checking bench for the motor starter supervisor.
// Assumes: Field model drives the field struct; one scan clock.
// Notes: Monitor and ready times are shortened through the registers.
`timescale 1ns/10ps
`include "mss_cfg.svh"
module mss_supervisor_tb_top;
    import mss_pkg::*;
    localparam logic [15:0] MON_T = 16'h0003;
    localparam logic [15:0] RDY_T = 16'h0005;
    logic clock, nrst = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, fb_cut = 1'b0, local_start = 1'b0;
    logic start_cmd, running, ready_for_auto, alarm, failed, irq;
    logic [3:0] reg_addr = 4'h0, fb_delay = 4'h1;
    logic [4:0] perm = 5'h1F;
    logic [7:0] status_alarm_in = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rdv;
    logic [15:0] rst_val [3] = '{16'h0001, `MSS_MON_TICKS_DEF, `MSS_RDY_TICKS_DEF};
    mss_field_t field;
    mss_cmd_t cmd = 5'h00;
    int n_fail = 0, check_count = 0;

    mss_supervisor dut (.clock(clock), .nrst(nrst), .clk_en(clk_en), .field(field),
        .status_alarm_in(status_alarm_in), .start_cmd(start_cmd), .cmd(cmd), .running(running),
        .ready_for_auto(ready_for_auto), .alarm(alarm), .failed(failed), .irq(irq), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    mss_field_model u_field (.clock(clock), .nrst(nrst), .start_cmd(start_cmd), .fb_delay(fb_delay),
        .fb_cut(fb_cut), .perm(perm), .local_start(local_start), .field(field));

    // Scan clock, 50 ns period.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task summarize;
        $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Lands just after the edge so registered outputs have settled.
    task step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    task wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        step(1);
        reg_wr <= 1'b0;
        step(1);
    endtask : wr

    task rd(input logic [3:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        step(1);
        d = reg_rdata;
        reg_rd <= 1'b0;
        step(1);
    endtask : rd

    // Commands are start 10, stop 08, restart 04, ack 02, jog 01.
    task pulse(input mss_cmd_t c);
        cmd <= c;
        step(1);
        cmd <= 5'h00;
    endtask : pulse

    task run_up(input logic auto_mode);
        pulse(5'h10);
        chk("start_cmd", start_cmd, 1'b1);
        step(MON_T);
        chk("early running", running, 1'b0);
        step(1);
        chk("running", running, 1'b1);
        step(RDY_T);
        chk("early ready", ready_for_auto, 1'b0);
        step(1);
        chk("ready_for_auto", ready_for_auto, auto_mode);
    endtask : run_up

    task clear_fault;
        perm <= 5'h1F;
        fb_cut <= 1'b0;
        pulse(5'h04);
        step(1);
        pulse(5'h02);
        step(2);
    endtask : clear_fault

    // A hang anywhere ends the run as a mismatch.
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        summarize();
    end

    initial begin
        repeat (5) @(posedge clock);
        #1;
        nrst <= 1'b1;
        step(1);
        chk("reset outputs", {start_cmd, running, ready_for_auto, alarm, failed, irq}, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            rd(i[3:0], rdv);
            chk("reset value", rdv, rst_val[i]);
        end
        rd(4'h8, rdv);
        chk("unmapped read", rdv, 16'h0000);
        wr(`MSS_OFS_MON, MON_T);
        wr(`MSS_OFS_RDY, RDY_T);
        wr(`MSS_OFS_CTRL, 16'h000A);
        wr(`MSS_OFS_IRQ_EN, 16'h000F);
        wr(`MSS_OFS_ALARM_EN, 16'h0001);
        run_up(1'b1);
        pulse(5'h08);
        chk("stop outputs", {start_cmd, running, ready_for_auto}, 16'h0000);
        rd(`MSS_OFS_IRQ_STAT, rdv);
        chk("run and stop events", rdv, 16'h0006);
        chk("irq raised", irq, 1'b1);
        wr(`MSS_OFS_IRQ_CLR, 16'h000F);
        chk("irq cleared", irq, 1'b0);
        // Missing safety, then missing protection outside local mode.
        for (int i = 0; i < 2; i++) begin
            perm <= i ? 5'h17 : 5'h0F;
            step(1);
            pulse(5'h10);
            step(1);
            chk("start refused", start_cmd, 1'b0);
        end
        perm <= 5'h1F;
        // Loss of feedback, then of each chain in turn, while running.
        for (int i = 0; i < 6; i++) begin
            run_up(1'b1);
            fb_cut <= (i == 0);
            perm <= 5'h1F ^ 5'(6'h20 >> i);
            step(2);
            chk("fault outputs", {failed, start_cmd, running, ready_for_auto}, 16'h0008);
            clear_fault();
        end
        wr(`MSS_OFS_IRQ_CLR, 16'h000F);
        wr(`MSS_OFS_IRQ_EN, 16'h0000);
        fb_delay <= 4'hF;
        pulse(5'h10);
        step(MON_T + 3);
        chk("late feedback", {failed, running, alarm, irq}, 16'h000A);
        pulse(5'h10);
        step(1);
        chk("start while failed", start_cmd, 1'b0);
        fb_delay <= 4'h1;
        pulse(5'h04);
        step(2);
        chk("alarm after restart", {failed, alarm}, 16'h0001);
        pulse(5'h02);
        step(2);
        chk("alarm acked", alarm, 1'b0);
        rd(`MSS_OFS_IRQ_STAT, rdv);
        chk("masked fail event", rdv & 16'h0009, 16'h0009);
        for (int i = 0; i < 2; i++) begin
            wr(`MSS_OFS_CTRL, i ? 16'h0008 : 16'h0009);
            cmd <= 5'h01;
            step(2);
            chk("jog", start_cmd, i[0]);
            cmd <= 5'h00;
            step(2);
        end
        wr(`MSS_OFS_CTRL, 16'h000C);
        perm <= 5'h17;
        local_start <= 1'b1;
        run_up(1'b0);
        rd(`MSS_OFS_STAT, rdv);
        chk("status word", rdv, 16'h0032);
        // A stop that arrives while the clock enable is low must be ignored.
        clk_en <= 1'b0;
        pulse(5'h08);
        step(1);
        chk("frozen run", {start_cmd, running}, 16'h0003);
        clk_en <= 1'b1;
        pulse(5'h08);
        chk("stop after freeze", {start_cmd, running}, 16'h0000);
        local_start <= 1'b0;
        perm <= 5'h1F;
        wr(`MSS_OFS_CTRL, 16'h0002);
        status_alarm_in <= 8'h01;
        step(2);
        chk("unchecked alarm", alarm, 1'b0);
        status_alarm_in <= 8'h02;
        wr(`MSS_OFS_CTRL, 16'h000A);
        chk("disabled alarm", alarm, 1'b0);
        status_alarm_in <= 8'h03;
        step(2);
        chk("status alarm", alarm, 1'b1);
        pulse(5'h02);
        step(1);
        chk("ack while present", alarm, 1'b1);
        status_alarm_in <= 8'h00;
        step(2);
        chk("latched alarm", alarm, 1'b1);
        pulse(5'h02);
        step(2);
        chk("alarm acked", alarm, 1'b0);
        summarize();
    end
endmodule : mss_supervisor_tb_top
